/* File: i2c_slave_conditions.sv */
// two-wire slave: bus conditions, address match and acknowledge
// assumes bus lines arrive asynchronously; open-drain pads outside
`timescale 1ns/1ps
module i2c_slave_conditions
   import i2c_slave_pkg::*;
#(
   parameter int FIFO_WORDS = FIFO_DEPTH
) (
   // clock and reset
   input wire logic clk_sys,
   input wire logic reset_n,
   // bus pins, open drain
   input wire logic busClockLineIn,
   output logic busClockLineOut,
   output logic busClockLineOe,
   input wire logic busDataLineIn,
   output logic busDataLineOut,
   output logic busDataLineOe,
   // configuration and software controls
   input wire i2c_slave_pkg::slaveCfg_t cfg,
   input wire logic portIrqClear,
   input wire logic overflowClear,
   input wire logic clockRelease,
   input wire logic ownAddressWritten,
   // transmit data from software
   input wire logic [7:0] txData,
   input wire logic txLoad,
   // receive buffer stream
   output logic rxValid,
   input wire logic rxReady,
   output logic [7:0] receiveBuffer,
   // status
   output logic portIrqFlag,
   output logic bufferFullFlag,
   output i2c_slave_pkg::slaveStat_t stat
);
   import i2c_slave_pkg::*;

   // ----------------------------------------
   // state
   // ----------------------------------------
   typedef struct packed {
      logic [1:0] sclSync;
      logic [1:0] sdaSync;
      logic sclPrev;
      logic sdaPrev;
      phase_t phase;
      logic [CNT_W-1:0] bitCnt;
      logic [7:0] shiftReg;
      logic [7:0] txShift;
      logic sdaLow;
      logic sclHold;
      logic lowSeen;
      logic ackPhase;
      logic ackDrive;
      logic readMode;
      logic firstByte;
      logic pushReq;
      logic [7:0] pushData;
      logic irq;
      logic startSeen;
      logic stopSeen;
      logic busActive;
      logic ackStatus;
      logic ackTime;
      logic readWrite;
      logic priorMatch;
      logic collision;
      logic overflow;
   } core_t;

   core_t s_r;
   core_t s_nxt;
   logic fifoInReady;
   logic fifoOutValid;
   logic [7:0] fifoOutData;

   // ----------------------------------------
   // receive buffer
   // ----------------------------------------
   byte_fifo #(
      .WIDTH(8),
      .DEPTH(FIFO_WORDS)
   ) rxFifo (
      .clk_sys(clk_sys),
      .reset_n(reset_n),
      .inValid(s_r.pushReq),
      .inReady(fifoInReady),
      .inData(s_r.pushData),
      .outValid(fifoOutValid),
      .outReady(rxReady),
      .outData(fifoOutData)
   );

   assign rxValid = fifoOutValid;
   assign receiveBuffer = fifoOutData;
   assign bufferFullFlag = !fifoInReady;

   // ----------------------------------------
   // condition and edge detection
   // ----------------------------------------
   logic scl;
   logic sda;
   logic sclRise;
   logic sclFall;
   logic startCond;
   logic stopCond;
   logic spMode;
   logic tenBit;
   logic holdBoth;
   logic holdAny;
   logic [7:0] maskedRx;
   logic [7:0] maskedOwn;
   logic addrMatch7;
   logic headMatch;
   logic lowMatch;
   logic [7:0] fullByte;

   assign scl = s_r.sclSync[1];
   assign sda = s_r.sdaSync[1];
   assign sclRise = scl && !s_r.sclPrev;
   assign sclFall = !scl && s_r.sclPrev;
   assign startCond = scl && s_r.sclPrev && s_r.sdaPrev && !sda;
   assign stopCond = scl && s_r.sclPrev && !s_r.sdaPrev && sda && s_r.lowSeen;
   assign spMode = cfg.portModeSelect[1];
   assign tenBit = cfg.portModeSelect[0];
   assign holdBoth = cfg.addressHoldEnable && cfg.dataHoldEnable;
   assign holdAny = cfg.addressHoldEnable || cfg.dataHoldEnable;
   assign fullByte = {s_r.shiftReg[6:0], sda};
   assign maskedRx = s_r.shiftReg & cfg.addressMask;
   assign maskedOwn = cfg.ownAddress & cfg.addressMask;
   assign addrMatch7 = (maskedRx[7:1] == maskedOwn[7:1]);
   assign headMatch = (s_r.shiftReg[7:3] == TEN_BIT_HEAD)
      && (s_r.shiftReg[2] == cfg.ownAddress[TEN_A9_POS])
      && (s_r.shiftReg[1] == cfg.ownAddress[TEN_A8_POS]);
   assign lowMatch = (maskedRx == maskedOwn);

   // ----------------------------------------
   // next state
   // ----------------------------------------
   always_comb begin
      s_nxt = s_r;
      s_nxt.sclSync = {s_r.sclSync[0], busClockLineIn};
      s_nxt.sdaSync = {s_r.sdaSync[0], busDataLineIn};
      s_nxt.sclPrev = scl;
      s_nxt.sdaPrev = sda;
      s_nxt.pushReq = 1'b0;
      if (portIrqClear) begin
         s_nxt.irq = 1'b0;
      end
      if (overflowClear) begin
         s_nxt.overflow = 1'b0;
      end
      if (clockRelease) begin
         s_nxt.sclHold = 1'b0;
      end
      if (txLoad) begin
         s_nxt.txShift = txData;
      end
      if (!scl) begin
         s_nxt.lowSeen = 1'b1;
      end
      if (scl && sda) begin
         s_nxt.busActive = s_r.busActive;
      end
      // collision: releasing for high but line is low
      if (scl && s_r.readMode && !s_r.sdaLow && !s_r.ackPhase && s_r.phase == ST_TX && !sda) begin
         s_nxt.collision = 1'b1;
         s_nxt.phase = ST_IDLE;
         s_nxt.readMode = 1'b0;
      end
      if (!cfg.portEnable) begin
         s_nxt.phase = ST_IDLE;
         s_nxt.sdaLow = 1'b0;
         s_nxt.sclHold = 1'b0;
         s_nxt.busActive = 1'b0;
      end else if (startCond) begin
         // start and restart share the same reset of slave logic
         if (s_r.sdaLow && s_r.phase == ST_IDLE) begin
            s_nxt.collision = 1'b1;
         end
         s_nxt.startSeen = 1'b1;
         s_nxt.stopSeen = 1'b0;
         s_nxt.busActive = 1'b1;
         s_nxt.lowSeen = 1'b0;
         s_nxt.phase = ST_ADDR;
         s_nxt.bitCnt = '0;
         s_nxt.sdaLow = 1'b0;
         s_nxt.sclHold = 1'b0;
         s_nxt.ackPhase = 1'b0;
         s_nxt.readMode = 1'b0;
         s_nxt.firstByte = 1'b1;
         if (spMode || cfg.startIrqEnable) begin
            s_nxt.irq = 1'b1;
         end
      end else if (stopCond) begin
         s_nxt.stopSeen = 1'b1;
         s_nxt.startSeen = 1'b0;
         s_nxt.busActive = 1'b0;
         s_nxt.phase = ST_IDLE;
         s_nxt.sdaLow = 1'b0;
         s_nxt.sclHold = 1'b0;
         s_nxt.readMode = 1'b0;
         s_nxt.priorMatch = 1'b0;
         if (spMode || cfg.stopIrqEnable) begin
            s_nxt.irq = 1'b1;
         end
      end else if (s_r.phase != ST_IDLE && s_r.phase != ST_WAIT) begin
         if (sclRise) begin
            if (s_r.ackPhase) begin
               if (s_r.readMode) begin
                  s_nxt.ackStatus = sda;
               end
            end else begin
               s_nxt.shiftReg = fullByte;
               s_nxt.bitCnt = s_r.bitCnt + 1'b1;
            end
         end
         if (sclFall) begin
            if (s_r.ackPhase) begin
               // ninth falling edge ends the byte
               s_nxt.ackPhase = 1'b0;
               s_nxt.ackTime = 1'b0;
               s_nxt.bitCnt = '0;
               s_nxt.sdaLow = 1'b0;
               if (s_r.readMode) begin
                  if (s_r.ackStatus) begin
                     s_nxt.phase = ST_IDLE;
                     s_nxt.readMode = 1'b0;
                  end else begin
                     s_nxt.phase = ST_TX;
                     s_nxt.sdaLow = !s_r.txShift[7];
                     s_nxt.txShift = {s_r.txShift[6:0], 1'b0};
                     s_nxt.irq = 1'b1;
                  end
               end else if (s_r.ackDrive) begin
                  s_nxt.irq = 1'b1;
               end
            end else if (s_r.bitCnt == CNT_W'(BYTE_BITS)) begin
               // eighth falling edge: decide the acknowledge
               s_nxt.ackPhase = 1'b1;
               s_nxt.ackDrive = 1'b0;
               s_nxt.sdaLow = 1'b0;
               s_nxt.firstByte = 1'b0;
               case (s_r.phase)
                  ST_ADDR: begin
                     if (tenBit) begin
                        if (headMatch && s_r.shiftReg[0] && s_r.priorMatch) begin
                           s_nxt.ackDrive = 1'b1;
                           s_nxt.readMode = 1'b1;
                           s_nxt.readWrite = 1'b1;
                           s_nxt.sclHold = 1'b1;
                        end else if (headMatch && !s_r.shiftReg[0]) begin
                           s_nxt.priorMatch = 1'b0;
                           s_nxt.ackDrive = 1'b1;
                           s_nxt.phase = ST_LOWADDR;
                        end else begin
                           s_nxt.priorMatch = 1'b0;
                           s_nxt.phase = ST_IDLE;
                        end
                     end else if (addrMatch7) begin
                        s_nxt.ackDrive = 1'b1;
                        s_nxt.readMode = s_r.shiftReg[0];
                        s_nxt.readWrite = s_r.shiftReg[0];
                        s_nxt.phase = s_r.shiftReg[0] ? ST_TX : ST_RX;
                        s_nxt.sclHold = s_r.shiftReg[0];
                     end else begin
                        s_nxt.phase = ST_IDLE;
                     end
                  end
                  ST_LOWADDR: begin
                     s_nxt.ackDrive = lowMatch;
                     s_nxt.priorMatch = lowMatch;
                     s_nxt.readWrite = 1'b0;
                     s_nxt.phase = lowMatch ? ST_RX : ST_IDLE;
                  end
                  ST_TX: begin
                     s_nxt.ackDrive = 1'b0;
                  end
                  default: begin
                     s_nxt.ackDrive = 1'b1;
                  end
               endcase
               if (s_r.phase != ST_TX && s_nxt.ackDrive) begin
                  if (holdAny) begin
                     s_nxt.ackTime = 1'b1;
                     s_nxt.irq = 1'b1;
                  end
                  if (bufferFullFlag || s_r.overflow) begin
                     s_nxt.ackDrive = 1'b0;
                     s_nxt.overflow = 1'b1;
                  end else begin
                     s_nxt.pushReq = (s_r.phase != ST_LOWADDR) || lowMatch;
                     s_nxt.pushData = s_r.shiftReg;
                  end
                  if (holdBoth) begin
                     s_nxt.ackDrive = s_nxt.ackDrive && !cfg.ackDataBit;
                  end
                  s_nxt.sdaLow = s_nxt.ackDrive;
               end
            end else if (s_r.phase == ST_TX && s_r.readMode) begin
               s_nxt.sdaLow = !s_r.txShift[7];
               s_nxt.txShift = {s_r.txShift[6:0], 1'b0};
            end
         end
      end
      if (ownAddressWritten && s_r.phase == ST_LOWADDR) begin
         s_nxt.sclHold = 1'b0;
      end
   end

   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         s_r <= '0;
         s_r.sclSync <= 2'h3;
         s_r.sdaSync <= 2'h3;
         s_r.sclPrev <= 1'b1;
         s_r.sdaPrev <= 1'b1;
         s_r.phase <= ST_IDLE;
      end else begin
         s_r <= s_nxt;
      end
   end

   // ----------------------------------------
   // pins and status
   // ----------------------------------------
   assign busDataLineOut = 1'b0;
   assign busDataLineOe = s_r.sdaLow;
   assign busClockLineOut = 1'b0;
   assign busClockLineOe = s_r.sclHold;
   assign portIrqFlag = s_r.irq;
   assign stat.startSeen = s_r.startSeen;
   assign stat.stopSeen = s_r.stopSeen;
   assign stat.busActive = s_r.busActive;
   assign stat.ackStatusBit = s_r.ackStatus;
   assign stat.ackTimeStatus = s_r.ackTime;
   assign stat.readWrite = s_r.readWrite;
   assign stat.priorMatch = s_r.priorMatch;
   assign stat.busCollision = s_r.collision;
   assign stat.receiveOverflowFlag = s_r.overflow;
endmodule

/* File: i2c_slave_pkg.sv */
// shared types and constants for the two-wire slave port
// assumes one system clock domain at 125 MHz
package i2c_slave_pkg;
   // ----------------------------------------
   // slave modes
   // ----------------------------------------
   typedef enum logic [1:0] {
      MODE_7BIT = 2'b00,
      MODE_10BIT = 2'b01,
      MODE_7BIT_SP = 2'b10,
      MODE_10BIT_SP = 2'b11
   } slaveMode_t;

   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_ADDR = 3'b001,
      ST_LOWADDR = 3'b010,
      ST_RX = 3'b011,
      ST_TX = 3'b100,
      ST_WAIT = 3'b101
   } phase_t;

   // ----------------------------------------
   // constants
   // ----------------------------------------
   localparam int BYTE_BITS = 8;
   localparam int ACK_BIT = 9;
   localparam int CNT_W = 4;
   localparam logic [4:0] TEN_BIT_HEAD = 5'h1E;
   localparam int TEN_A9_POS = 2;
   localparam int TEN_A8_POS = 1;
   localparam int FIFO_DEPTH = 4;
   localparam logic [7:0] ADDR_RESET = 8'h00;
   localparam logic [7:0] MASK_RESET = 8'hFF;

   // ----------------------------------------
   // carriers
   // ----------------------------------------
   typedef struct packed {
      logic [7:0] ownAddress;
      logic [7:0] addressMask;
      slaveMode_t portModeSelect;
      logic portEnable;
      logic addressHoldEnable;
      logic dataHoldEnable;
      logic ackDataBit;
      logic startIrqEnable;
      logic stopIrqEnable;
   } slaveCfg_t;

   typedef struct packed {
      logic startSeen;
      logic stopSeen;
      logic busActive;
      logic ackStatusBit;
      logic ackTimeStatus;
      logic readWrite;
      logic priorMatch;
      logic busCollision;
      logic receiveOverflowFlag;
   } slaveStat_t;
endpackage

/* File: byte_fifo.sv */
// small synchronous FIFO with valid/ready on both sides
// assumes one clock, asynchronous active-low reset
`timescale 1ns/1ps
module byte_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 4
) (
   // clock and reset
   input wire logic clk_sys,
   input wire logic reset_n,
   // fill side
   input wire logic inValid,
   output logic inReady,
   input wire logic [WIDTH-1:0] inData,
   // drain side
   output logic outValid,
   input wire logic outReady,
   output logic [WIDTH-1:0] outData
);
   localparam int AW = $clog2(DEPTH);
   typedef struct packed {
      logic [AW-1:0] wrPtr;
      logic [AW-1:0] rdPtr;
      logic [AW:0] count;
   } fifoState_t;

   logic [WIDTH-1:0] mem [DEPTH];
   fifoState_t state_r;
   fifoState_t state_nxt;
   logic doWrite;
   logic doRead;

   assign inReady = (state_r.count != (AW+1)'(DEPTH));
   assign outValid = (state_r.count != '0);
   assign outData = mem[state_r.rdPtr];
   assign doWrite = inValid && inReady;
   assign doRead = outValid && outReady;

   always_comb begin
      state_nxt = state_r;
      if (doWrite) begin
         state_nxt.wrPtr = (state_r.wrPtr == AW'(DEPTH - 1)) ? '0 : state_r.wrPtr + 1'b1;
      end
      if (doRead) begin
         state_nxt.rdPtr = (state_r.rdPtr == AW'(DEPTH - 1)) ? '0 : state_r.rdPtr + 1'b1;
      end
      if (doWrite && !doRead) begin
         state_nxt.count = state_r.count + 1'b1;
      end else if (doRead && !doWrite) begin
         state_nxt.count = state_r.count - 1'b1;
      end
   end

   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         state_r <= '0;
      end else begin
         state_r <= state_nxt;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (doWrite) begin
         mem[state_r.wrPtr] <= inData;
      end
   end
endmodule

/* File: i2c_slave_conditions_props.sv */
// checker for the two-wire slave port, bound to its top module
// assumes bus lines arrive asynchronously to clk_sys
`timescale 1ns/1ps
module i2c_slave_conditions_props
   import i2c_slave_pkg::*;
#(
   parameter int FIFO_WORDS = 4
) (
   // clock and reset
   input wire logic clk_sys,
   input wire logic reset_n,
   // bus pins
   input wire logic busClockLineIn,
   input wire logic busClockLineOut,
   input wire logic busDataLineIn,
   input wire logic busDataLineOut,
   input wire logic busDataLineOe,
   // configuration and status
   input wire i2c_slave_pkg::slaveCfg_t cfg,
   input wire logic rxValid,
   input wire logic portIrqFlag,
   input wire logic bufferFullFlag,
   input wire i2c_slave_pkg::slaveStat_t stat
);
   logic [1:0] sclQ, sdaQ;
   logic sdaD, lowSeen;
   // ----------------------------------------
   // line samples and clock-low since start
   // ----------------------------------------
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         sclQ <= 2'h3;
         sdaQ <= 2'h3;
         sdaD <= 1'b1;
         lowSeen <= 1'b0;
      end else begin
         sclQ <= {sclQ[0], busClockLineIn};
         sdaQ <= {sdaQ[0], busDataLineIn};
         sdaD <= sdaQ[1];
         if (sdaD && !sdaQ[1] && sclQ[1]) begin
            lowSeen <= 1'b0;
         end else if (!sclQ[1]) begin
            lowSeen <= 1'b1;
         end
      end
   end
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!reset_n);
   sequence lineStart;
      cfg.portEnable && sdaD && !sdaQ[1] && sclQ[1];
   endsequence
   sequence lineStop;
      cfg.portEnable && !sdaD && sdaQ[1] && sclQ[1] && lowSeen;
   endsequence
   a_pins_open_drain: assert property (!busClockLineOut && !busDataLineOut)
      else $error("pin driven high");
   a_start_detected: assert property (lineStart |-> ##[0:4] stat.startSeen)
      else $error("start not seen");
   a_start_bus_active: assert property ($rose(stat.startSeen) |-> ##[0:2] stat.busActive)
      else $error("bus not active after start");
   a_stop_detected: assert property (lineStop |-> ##[0:4] stat.stopSeen)
      else $error("stop not seen");
   a_stop_bus_idle: assert property ($rose(stat.stopSeen) |-> ##[0:2] !stat.busActive)
      else $error("bus active after stop");
   a_stop_needs_low: assert property ($rose(stat.stopSeen) |-> lowSeen)
      else $error("stop without clock low");
   a_stop_irq_mode: assert property ($rose(stat.stopSeen) && cfg.portModeSelect[1] |-> ##[0:3] portIrqFlag)
      else $error("no flag on stop");
   a_acktime_hold: assert property ($rose(stat.ackTimeStatus) |-> cfg.addressHoldEnable || cfg.dataHoldEnable)
      else $error("ack time without hold");
   a_soft_nack: assert property ($rose(stat.ackTimeStatus) && cfg.addressHoldEnable && cfg.dataHoldEnable
      && cfg.ackDataBit |-> !busDataLineOe [*8])
      else $error("ack driven against software");
   a_collision_kept: assert property (stat.busCollision |=> stat.busCollision)
      else $error("collision lost");
   a_full_has_data: assert property (bufferFullFlag |-> rxValid)
      else $error("full but empty");
endmodule

bind i2c_slave_conditions i2c_slave_conditions_props #(.FIFO_WORDS(FIFO_WORDS)) props (
   .clk_sys(clk_sys), .reset_n(reset_n), .busClockLineIn(busClockLineIn),
   .busClockLineOut(busClockLineOut), .busDataLineIn(busDataLineIn),
   .busDataLineOut(busDataLineOut), .busDataLineOe(busDataLineOe), .cfg(cfg),
   .rxValid(rxValid), .portIrqFlag(portIrqFlag), .bufferFullFlag(bufferFullFlag), .stat(stat)
);

/* File: i2c_master_model.sv */
// bus master model on the far side of the slave port
// assumes pull-ups on both lines, wired levels fed back in
`timescale 1ns/1ps
module i2c_master_model (
   // wired line levels
   input wire logic sclWire,
   input wire logic sdaWire,
   // master pull-downs
   output logic sclLow,
   output logic sdaLow
);
   localparam realtime Q = 31.25;
   initial begin
      sclLow = 1'b0;
      sdaLow = 1'b0;
   end
   // raise clock, wait out stretching
   task automatic clkUp();
      int n;
      sclLow = 1'b0;
      n = 0;
      while (!sclWire && n < 4000) begin
         #8;
         n++;
      end
   endtask
   // one bit, sampled while clock high
   task automatic bitX(input logic b, output logic s);
      sdaLow = !b;
      #Q;
      clkUp();
      #Q;
      s = sdaWire;
      #Q;
      sclLow = 1'b1;
      #Q;
   endtask
   // start or restart when rise is 0, stop when 1
   task automatic cond(input logic rise);
      sdaLow = rise;
      #Q;
      clkUp();
      #Q;
      sdaLow = !rise;
      #Q;
      if (!rise) begin
         sclLow = 1'b1;
         #Q;
      end
   endtask
   // data dips and returns with clock held high
   task automatic glitch();
      sdaLow = 1'b1;
      #Q;
      sdaLow = 1'b0;
      #Q;
   endtask
   // eight bits msb first, then the ninth
   task automatic xfer(input logic [7:0] tx, input logic ackIn, output logic [7:0] rx, output logic ackOut);
      logic s;
      for (int i = 7; i >= 0; i--) begin
         bitX(tx[i], s);
         rx[i] = s;
      end
      bitX(ackIn, ackOut);
   endtask
endmodule

/* File: i2c_slave_bus_conditions_ack_test.sv */
// self-checking bench for the two-wire slave port
// assumes the master model on the far side; held clock released at once
`timescale 1ns/1ps
module i2c_slave_bus_conditions_ack_test;
   import i2c_slave_pkg::*;
   logic clk_sys, reset_n, sclLow, sdaLow, sclWire, sdaWire, ack;
   logic busClockLineOut, busClockLineOe, busDataLineOut, busDataLineOe;
   logic portIrqClear, overflowClear, clockRelease, txLoad, rxValid, rxReady, ownAddressWritten;
   logic portIrqFlag, bufferFullFlag;
   logic [7:0] txData, receiveBuffer, rxb;
   slaveCfg_t cfg;
   slaveStat_t stat;
   int badCount, nCompared;
   assign sclWire = (busClockLineOe ? busClockLineOut : 1'b1) & !sclLow;
   assign sdaWire = (busDataLineOe ? busDataLineOut : 1'b1) & !sdaLow;
   i2c_slave_conditions uut (
      .clk_sys(clk_sys), .reset_n(reset_n), .busClockLineIn(sclWire),
      .busClockLineOut(busClockLineOut), .busClockLineOe(busClockLineOe),
      .busDataLineIn(sdaWire), .busDataLineOut(busDataLineOut), .busDataLineOe(busDataLineOe),
      .cfg(cfg), .portIrqClear(portIrqClear), .overflowClear(overflowClear),
      .clockRelease(clockRelease), .ownAddressWritten(ownAddressWritten), .txData(txData), .txLoad(txLoad),
      .rxValid(rxValid), .rxReady(rxReady), .receiveBuffer(receiveBuffer),
      .portIrqFlag(portIrqFlag), .bufferFullFlag(bufferFullFlag), .stat(stat)
   );
   i2c_master_model mst (.sclWire(sclWire), .sdaWire(sdaWire), .sclLow(sclLow), .sdaLow(sdaLow));
   initial begin
      clk_sys = 1'b0;
      forever #4 clk_sys = ~clk_sys;
   end
   always @(posedge clk_sys) clockRelease <= busClockLineOe && !clockRelease;
   // ----------------------------------------
   // tasks
   // ----------------------------------------
   task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
      nCompared++;
      if (seen !== exp) begin
         badCount++;
         $display("unexpected %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic settle();
      repeat (6) @(posedge clk_sys);
      #1;
   endtask
   task automatic send(input logic [7:0] b, input logic expAck);
      mst.xfer(b, 1'b1, rxb, ack);
      check("ack", 8'(ack), 8'(expAck));
   endtask
   task automatic strobe(input int k);
      @(posedge clk_sys);
      case (k)
         0: portIrqClear <= 1'b1;
         1: overflowClear <= 1'b1;
         2: txLoad <= 1'b1;
         default: ownAddressWritten <= 1'b1;
      endcase
      @(posedge clk_sys);
      {portIrqClear, overflowClear, txLoad, ownAddressWritten} <= 4'h0;
      #1;
   endtask
   task automatic pop(input logic [7:0] exp);
      check("rxValid", 8'(rxValid), 8'h01);
      check("receiveBuffer", receiveBuffer, exp);
      @(posedge clk_sys) rxReady <= 1'b1;
      @(posedge clk_sys) rxReady <= 1'b0;
      #1;
   endtask
   task automatic closeOut();
      $display("compared %0d mismatches %0d", nCompared, badCount);
      if (badCount == 0 && nCompared > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   initial begin
      #300us;
      badCount++;
      closeOut();
   end
   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   initial begin
      reset_n = 1'b0;
      cfg = '{ownAddress: 8'hA4, addressMask: 8'hFF, portModeSelect: MODE_7BIT, portEnable: 1'b1, default: 1'b0};
      {portIrqClear, overflowClear, txLoad, rxReady, ownAddressWritten} = 5'h0;
      txData = 8'h3C;
      badCount = 0;
      nCompared = 0;
      repeat (8) @(posedge clk_sys);
      reset_n <= 1'b1;
      settle();
      mst.cond(1'b0);
      settle();
      check("startSeen", 8'(stat.startSeen), 8'h01);
      check("busActive", 8'(stat.busActive), 8'h01);
      send(8'hA4, 1'b0);
      send(8'h5A, 1'b0);
      settle();
      check("portIrqFlag", 8'(portIrqFlag), 8'h01);
      pop(8'hA4);
      pop(8'h5A);
      strobe(0);
      mst.cond(1'b0);
      send(8'hA6, 1'b1);
      mst.cond(1'b1);
      settle();
      check("stopSeen", 8'(stat.stopSeen), 8'h01);
      check("busActive", 8'(stat.busActive), 8'h00);
      check("portIrqFlag", 8'(portIrqFlag), 8'h00);
      check("rxValid", 8'(rxValid), 8'h00);
      @(posedge clk_sys) cfg.addressMask <= 8'hF7;
      mst.cond(1'b0);
      send(8'hAC, 1'b0);
      mst.cond(1'b1);
      @(posedge clk_sys) cfg.addressMask <= 8'hFF;
      settle();
      pop(8'hAC);
      strobe(0);
      strobe(2);
      mst.cond(1'b0);
      send(8'hA5, 1'b0);
      mst.xfer(8'hFF, 1'b1, rxb, ack);
      check("readData", rxb, 8'h3C);
      settle();
      check("readWrite", 8'(stat.readWrite), 8'h01);
      check("ackStatusBit", 8'(stat.ackStatusBit), 8'h01);
      mst.cond(1'b1);
      settle();
      pop(8'hA5);
      strobe(0);
      mst.cond(1'b0);
      send(8'hA4, 1'b0);
      for (int i = 1; i < 4; i++) begin
         send(8'(i), 1'b0);
      end
      check("bufferFullFlag", 8'(bufferFullFlag), 8'h01);
      send(8'h04, 1'b1);
      mst.cond(1'b1);
      settle();
      check("overflow", 8'(stat.receiveOverflowFlag), 8'h01);
      pop(8'hA4);
      for (int i = 1; i < 4; i++) begin
         pop(8'(i));
      end
      check("rxValid", 8'(rxValid), 8'h00);
      strobe(1);
      check("overflow", 8'(stat.receiveOverflowFlag), 8'h00);
      strobe(0);
      @(posedge clk_sys) cfg.portModeSelect <= MODE_7BIT_SP;
      mst.glitch();
      settle();
      check("startSeen", 8'(stat.startSeen), 8'h01);
      check("busActive", 8'(stat.busActive), 8'h01);
      check("portIrqFlag", 8'(portIrqFlag), 8'h01);
      strobe(0);
      mst.cond(1'b0);
      strobe(0);
      mst.cond(1'b1);
      settle();
      check("stopSeen", 8'(stat.stopSeen), 8'h01);
      check("portIrqFlag", 8'(portIrqFlag), 8'h01);
      strobe(0);
      @(posedge clk_sys) cfg.portModeSelect <= MODE_10BIT;
      @(posedge clk_sys) cfg.ownAddress <= 8'h32;
      strobe(3);
      @(posedge clk_sys) txData <= 8'h96;
      strobe(2);
      mst.cond(1'b0);
      send(8'hF2, 1'b0);
      send(8'h32, 1'b0);
      mst.cond(1'b0);
      send(8'hF3, 1'b0);
      mst.xfer(8'hFF, 1'b1, rxb, ack);
      check("readData", rxb, 8'h96);
      check("priorMatch", 8'(stat.priorMatch), 8'h01);
      mst.cond(1'b1);
      settle();
      check("priorMatch", 8'(stat.priorMatch), 8'h00);
      pop(8'hF2);
      pop(8'h32);
      pop(8'hF3);
      strobe(0);
      @(posedge clk_sys) cfg.portModeSelect <= MODE_7BIT;
      @(posedge clk_sys) cfg.ownAddress <= 8'hA4;
      for (int k = 0; k < 2; k++) begin
         @(posedge clk_sys) {cfg.startIrqEnable, cfg.stopIrqEnable} <= k[0] ? 2'h1 : 2'h2;
         mst.cond(1'b0);
         settle();
         check("portIrqFlag", 8'(portIrqFlag), 8'(!k[0]));
         strobe(0);
         mst.cond(1'b1);
         settle();
         check("portIrqFlag", 8'(portIrqFlag), 8'(k[0]));
         strobe(0);
      end
      @(posedge clk_sys) {cfg.portEnable, cfg.startIrqEnable, cfg.stopIrqEnable} <= 3'h0;
      mst.cond(1'b0);
      settle();
      check("startSeen", 8'(stat.startSeen), 8'h00);
      mst.cond(1'b1);
      @(posedge clk_sys) cfg.portEnable <= 1'b1;
      @(posedge clk_sys) {cfg.addressHoldEnable, cfg.dataHoldEnable} <= 2'h3;
      for (int k = 0; k < 2; k++) begin
         @(posedge clk_sys) cfg.ackDataBit <= k[0];
         mst.cond(1'b0);
         send(8'hA4, k[0]);
         mst.cond(1'b1);
         settle();
      end
      closeOut();
   end
endmodule
